// ===== verilog/oaf_pkg.sv
// package for the oversampling average filter: constants and carrier types
package oaf_pkg;
    localparam int NUM_CH = 8;
    localparam int CODE_W = 18;
    localparam int ACC_W = 26;
    localparam logic [7:0] OSR_REG_ADDR = 8'h08;
    localparam logic [7:0] OSR_REG_RESET = 8'h00;
    localparam logic [2:0] PINS_SW_MODE = 3'h7;
    localparam logic [3:0] SHIFT_MAX = 4'h8;
    // conversion latency of one sample inside the filter, in ns and rounded up to cycles
    localparam int CONV_NS = 400;
    localparam int CLK_NS = 40;
    localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;
    // spacing of the internal sample strobe
    localparam int STROBE_NS = 1000;
    localparam int STROBE_CYCLES = STROBE_NS / CLK_NS;
    localparam logic [7:0] STROBE_RELOAD = 8'(STROBE_CYCLES - 1);

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } oaf_reg_req_t;

    typedef enum logic [1:0] {
        OAF_IDLE,
        OAF_WAIT,
        OAF_DONE
    } oaf_state_t;
endpackage : oaf_pkg

// ===== verilog/oaf_filter.sv
// oversampling average filter: ratio select, sample sequencing, accumulate and average
`timescale 1ns/10ps

// Behaviour
// - With no averaging each result is a single conversion, otherwise several are averaged.
// - In hardware mode the ratio comes from the three ratio-select pins.
// - The pin levels are captured only at busy falling edge or full reset.
// - All-ones pins select software mode, with the ratio from register 0x08.
// - Software mode also offers ratios 128 and 256.
// - The first sample of each run is taken on the convert-start rising edge.
// - Further samples are triggered by the internal sample strobe.
// - A ratio N takes exactly N samples per channel and gives one result.
// - With the external strobe option further samples come from the external strobe.
// - Busy stays high for the whole multi-sample run.
// - The previous result stays readable while a run is in progress.
// - Pin codes 000..110 mean none,2,4,8,16,32,64 and 111 means software mode.
// - A partial reset aborts any run and clears the results.
module oaf_filter (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic full_reset,
    input wire logic partial_reset,
    input wire logic [2:0] ratio_select_pins,
    input wire logic convert_start,
    input wire logic ext_strobe_en,
    input wire logic ext_sample_strobe,
    input wire oaf_pkg::oaf_reg_req_t reg_req,
    input wire logic [oaf_pkg::NUM_CH*oaf_pkg::CODE_W-1:0] conv_codes,
    input wire logic [2:0] rd_channel,
    output logic [7:0] reg_rdata,
    output logic sample_now,
    output logic busy,
    output logic result_valid,
    output logic [oaf_pkg::CODE_W-1:0] rd_data,
    output logic sw_mode
);
    localparam int W = oaf_pkg::CODE_W;
    localparam int A = oaf_pkg::ACC_W;

    logic [2:0] pins_reg;
    logic [7:0] osr_reg;
    logic busy_d_reg;
    logic cs_d_reg;
    logic ext_d_reg;
    logic [3:0] shift_reg;
    logic [8:0] count_reg;
    logic [7:0] strobe_reg;
    logic [7:0] conv_reg;
    logic [A-1:0] acc_reg [oaf_pkg::NUM_CH];
    logic [W-1:0] res_reg [oaf_pkg::NUM_CH];
    oaf_pkg::oaf_state_t state_reg;

    logic cs_rise;
    logic ext_rise;
    logic [3:0] shift_next;
    logic [8:0] n_total;
    logic conv_done;
    logic next_trig;

    assign cs_rise = convert_start && !cs_d_reg;
    assign ext_rise = ext_sample_strobe && !ext_d_reg;
    assign conv_done = (state_reg == oaf_pkg::OAF_WAIT) && (conv_reg == 8'h00);
    assign n_total = 9'h001 << shift_reg;

    // ratio decode, pins or register
    always_comb begin
        if (pins_reg == oaf_pkg::PINS_SW_MODE) begin
            shift_next = (osr_reg[3:0] > oaf_pkg::SHIFT_MAX) ? oaf_pkg::SHIFT_MAX
                                                              : osr_reg[3:0];
        end else begin
            shift_next = {1'b0, pins_reg};
        end
    end

    // pins latched at busy fall or full reset only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pins_reg <= 3'h0;
        end else if (full_reset || (busy_d_reg && !busy)) begin
            pins_reg <= ratio_select_pins;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osr_reg <= oaf_pkg::OSR_REG_RESET;
        end else if (full_reset) begin
            osr_reg <= oaf_pkg::OSR_REG_RESET;
        end else if (reg_req.wr && reg_req.addr == oaf_pkg::OSR_REG_ADDR) begin
            osr_reg <= reg_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            sw_mode <= 1'b0;
            busy_d_reg <= 1'b0;
            cs_d_reg <= 1'b0;
            ext_d_reg <= 1'b0;
        end else begin
            reg_rdata <= (reg_req.addr == oaf_pkg::OSR_REG_ADDR) ? osr_reg : 8'h00;
            sw_mode <= (pins_reg == oaf_pkg::PINS_SW_MODE);
            busy_d_reg <= busy;
            cs_d_reg <= convert_start;
            ext_d_reg <= ext_sample_strobe;
        end
    end

    // trigger of further samples: internal strobe or external one
    always_comb begin
        if (ext_strobe_en) begin
            next_trig = ext_rise;
        end else begin
            next_trig = (strobe_reg == 8'h00);
        end
    end

    // sequencer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= oaf_pkg::OAF_IDLE;
            busy <= 1'b0;
            sample_now <= 1'b0;
            shift_reg <= 4'h0;
            count_reg <= 9'h000;
            strobe_reg <= 8'h00;
            conv_reg <= 8'h00;
        end else if (partial_reset || full_reset) begin
            state_reg <= oaf_pkg::OAF_IDLE;
            busy <= 1'b0;
            sample_now <= 1'b0;
            count_reg <= 9'h000;
            conv_reg <= 8'h00;
        end else begin
            sample_now <= 1'b0;
            if (strobe_reg != 8'h00) begin
                strobe_reg <= strobe_reg - 8'h01;
            end
            if (conv_reg != 8'h00) begin
                conv_reg <= conv_reg - 8'h01;
            end
            case (state_reg)
                oaf_pkg::OAF_IDLE: begin
                    if (cs_rise) begin
                        shift_reg <= shift_next;
                        count_reg <= 9'h000;
                        busy <= 1'b1;
                        sample_now <= 1'b1;
                        conv_reg <= 8'(oaf_pkg::CONV_CYCLES);
                        strobe_reg <= oaf_pkg::STROBE_RELOAD;
                        state_reg <= oaf_pkg::OAF_WAIT;
                    end
                end
                oaf_pkg::OAF_WAIT: begin
                    if (conv_done) begin
                        count_reg <= count_reg + 9'h001;
                        state_reg <= oaf_pkg::OAF_DONE;
                    end
                end
                oaf_pkg::OAF_DONE: begin
                    if (count_reg == n_total) begin
                        busy <= 1'b0;
                        state_reg <= oaf_pkg::OAF_IDLE;
                    end else if (next_trig) begin
                        sample_now <= 1'b1;
                        conv_reg <= 8'(oaf_pkg::CONV_CYCLES);
                        strobe_reg <= oaf_pkg::STROBE_RELOAD;
                        state_reg <= oaf_pkg::OAF_WAIT;
                    end
                end
                default: state_reg <= oaf_pkg::OAF_IDLE;
            endcase
        end
    end

    // per channel accumulate and average
    for (genvar c = 0; c < oaf_pkg::NUM_CH; c++) begin : g_ch
        logic [W-1:0] code;
        logic [A-1:0] sum;
        assign code = conv_codes[c*W +: W];
        assign sum = ((count_reg == 9'h000) ? '0 : acc_reg[c]) + A'(code);

        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                acc_reg[c] <= '0;
            end else if (partial_reset || full_reset) begin
                acc_reg[c] <= '0;
            end else if (conv_done) begin
                acc_reg[c] <= sum;
            end
        end

        // old result kept until the run ends, so it stays readable while busy
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                res_reg[c] <= '0;
            end else if (partial_reset || full_reset) begin
                res_reg[c] <= '0;
            end else if (state_reg == oaf_pkg::OAF_DONE && count_reg == n_total) begin
                res_reg[c] <= W'(acc_reg[c] >> shift_reg);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
            result_valid <= 1'b0;
        end else begin
            rd_data <= res_reg[rd_channel];
            if (partial_reset || full_reset) begin
                result_valid <= 1'b0;
            end else if (state_reg == oaf_pkg::OAF_DONE && count_reg == n_total) begin
                result_valid <= 1'b1;
            end else if (cs_rise) begin
                result_valid <= 1'b0;
            end
        end
    end

    // checks
    property p_pins_hold;
        @(posedge clock) disable iff (!arst_n)
        (!full_reset && !($past(busy) && !busy)) |=> $stable(pins_reg);
    endproperty
    a_pins_hold: assert property (p_pins_hold) else $error("pins changed");

    property p_start;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg == oaf_pkg::OAF_IDLE && cs_rise) |=> (busy && sample_now);
    endproperty
    a_start: assert property (p_start) else $error("no start on edge");

    property p_busy_count;
        @(posedge clock) disable iff (!arst_n)
        $fell(busy) && !$past(partial_reset) && !$past(full_reset)
            |-> $past(count_reg) == $past(n_total);
    endproperty
    a_busy_count: assert property (p_busy_count) else $error("wrong sample count");

    property p_busy_hold;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg != oaf_pkg::OAF_IDLE) |-> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy low in run");

    property p_res_stable;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (busy && $past(busy)) |-> res_reg[0] == $past(res_reg[0]);
    endproperty
    a_res_stable: assert property (p_res_stable) else $error("result changed in run");

    property p_preset;
        @(posedge clock) disable iff (!arst_n)
        partial_reset |=> (!busy && res_reg[0] == '0 && state_reg == oaf_pkg::OAF_IDLE);
    endproperty
    a_preset: assert property (p_preset) else $error("partial reset ignored");

    property p_hw_ratio;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg == oaf_pkg::OAF_IDLE && cs_rise && pins_reg != oaf_pkg::PINS_SW_MODE)
            |=> shift_reg == {1'b0, $past(pins_reg)};
    endproperty
    a_hw_ratio: assert property (p_hw_ratio) else $error("hw ratio decode");

    property p_sw_cap;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg == oaf_pkg::OAF_IDLE && cs_rise && pins_reg == oaf_pkg::PINS_SW_MODE)
            |=> (shift_reg == oaf_pkg::SHIFT_MAX || shift_reg == $past(osr_reg[3:0]))
                && shift_reg <= oaf_pkg::SHIFT_MAX;
    endproperty
    a_sw_cap: assert property (p_sw_cap) else $error("sw ratio range");

    property p_int_strobe;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg == oaf_pkg::OAF_DONE && count_reg != n_total && !ext_strobe_en
            && strobe_reg != 8'h00) |=> !sample_now;
    endproperty
    a_int_strobe: assert property (p_int_strobe) else $error("early strobe");

    property p_pulse;
        @(posedge clock) disable iff (!arst_n)
        sample_now |=> !sample_now;
    endproperty
    a_pulse: assert property (p_pulse) else $error("sample pulse too long");

    // edge rebuilt from the pin and the design's ext_d_reg, not taken from the ext_rise signal
    property p_ext_only;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg == oaf_pkg::OAF_DONE && count_reg != n_total && ext_strobe_en
            && !(ext_sample_strobe && !ext_d_reg)) |=> !sample_now;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("sample without ext strobe");

    // one conversion of ten cycles plus start, done and release edges
    property p_single;
        @(posedge clock) disable iff (!arst_n || partial_reset || full_reset)
        (state_reg == oaf_pkg::OAF_IDLE && cs_rise && shift_next == 4'h0)
            |-> ##12 busy ##1 !busy;
    endproperty
    a_single: assert property (p_single) else $error("single conversion run length");

    c_run: cover property (@(posedge clock) disable iff (!arst_n) $fell(busy));
    c_sw: cover property (@(posedge clock) disable iff (!arst_n) sw_mode && busy);
    c_ext: cover property (@(posedge clock) disable iff (!arst_n) ext_strobe_en && sample_now);
    c_abort: cover property (@(posedge clock) disable iff (!arst_n) partial_reset && busy);
endmodule : oaf_filter

// ===== test/oaf_conv_model.sv
// conversion source model: fresh codes on all channels after every sample strobe
`timescale 1ns/10ps
module oaf_conv_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sample_now,
    input wire logic [17:0] base,
    input wire logic [17:0] step,
    output logic [143:0] conv_codes,
    output logic [15:0] taken
);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            taken <= 16'h0000;
        end else if (sample_now) begin
            taken <= taken + 16'h0001;
        end
    end
    // codes move per sample, so a wrong sample count or order shifts the mean
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            conv_codes[c*18 +: 18] = 18'(base + step * taken + 18'(c * 977));
        end
    end
endmodule : oaf_conv_model

// ===== test/tb.sv
// testbench for the oversampling average filter
`timescale 1ns/10ps
module tb;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic full_reset = 1'b0;
    logic partial_reset = 1'b0;
    logic [2:0] ratio_select_pins = 3'h0;
    logic [2:0] pins_next = 3'h0;
    logic convert_start = 1'b0;
    logic ext_strobe_en = 1'b0;
    logic ext_sample_strobe = 1'b0;
    oaf_pkg::oaf_reg_req_t reg_req = '0;
    logic [143:0] conv_codes;
    logic [2:0] rd_channel = 3'h0;
    logic [7:0] reg_rdata;
    logic sample_now;
    logic busy;
    logic result_valid;
    logic sw_mode;
    logic [17:0] rd_data;
    logic [17:0] base = 18'h0_0000;
    logic [17:0] step = 18'h0_0000;
    logic [15:0] taken;
    logic [17:0] prev [8];
    int error_cnt = 0;
    int checked = 0;
    int t0;
    always #20 clock = ~clock;
    oaf_filter dut (.clock(clock), .arst_n(arst_n), .full_reset(full_reset),
        .partial_reset(partial_reset), .ratio_select_pins(ratio_select_pins),
        .convert_start(convert_start), .ext_strobe_en(ext_strobe_en),
        .ext_sample_strobe(ext_sample_strobe), .reg_req(reg_req), .conv_codes(conv_codes),
        .rd_channel(rd_channel), .reg_rdata(reg_rdata), .sample_now(sample_now),
        .busy(busy), .result_valid(result_valid), .rd_data(rd_data), .sw_mode(sw_mode));
    oaf_conv_model conv (.clock(clock), .arst_n(arst_n), .sample_now(sample_now),
        .base(base), .step(step), .conv_codes(conv_codes), .taken(taken));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // mean of the codes the model hands out for samples t0+1 .. t0+2**sh
    function automatic logic [17:0] mean_of(input int ch, input int t, input int sh);
        logic [25:0] s;
        s = 26'h000_0000;
        for (int i = 1; i <= (1 << sh); i++) begin
            s += 26'(18'(base + step * 18'(t + i) + 18'(ch * 977)));
        end
        return 18'(s >> sh);
    endfunction : mean_of
    // rdata is registered and a write lands on the first edge, so the answer is looked at two edges after the address
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        reg_req = '{wr, a, d};
        tick(1);
        reg_req = '{1'b0, a, 8'h00};
        tick(1);
    endtask : reg_acc
    task automatic do_reset(input logic full);
        full_reset = full;
        partial_reset = !full;
        tick(1);
        full_reset = 1'b0;
        partial_reset = 1'b0;
        check("abort busy", busy, 0);
        check("valid clear", result_valid, 0);
        for (int c = 0; c < 8; c++) prev[c] = 18'h0_0000;
        tick(1);
    endtask : do_reset
    task automatic run(input int sh, input logic ext);
        int n;
        base = 18'($urandom);
        step = 18'($urandom);
        t0 = taken;
        ext_strobe_en = ext;
        // a run starts only once the last results were read, so the rate stays legal
        convert_start = 1'b1;
        tick(2);
        convert_start = 1'b0;
        check("busy rise", busy, 1);
        check("valid drop", result_valid, 0);
        n = 0;
        while (busy && n < 8000) begin
            if (n == 3) check("prev held", rd_data, prev[rd_channel]);
            convert_start = (n == 5);
            if (n == 10) ratio_select_pins = pins_next;
            if (ext && n == 60) check("ext wait", taken - t0, 1);
            ext_sample_strobe = ext && n > 60 && n % 30 < 2;
            tick(1);
            n++;
        end
        ext_sample_strobe = 1'b0;
        ext_strobe_en = 1'b0;
        check("samples", taken - t0, 1 << sh);
        check("valid", result_valid, 1);
        for (int c = 0; c < 8; c++) begin
            rd_channel = 3'(c);
            tick(1);
            prev[c] = mean_of(c, t0, sh);
            check("mean", rd_data, prev[c]);
        end
    endtask : run
    initial begin
        logic [7:0] osr_val;
        void'($urandom(95153));
        for (int c = 0; c < 8; c++) prev[c] = 18'h0_0000;
        tick(16);
        arst_n = 1'b1;
        tick(1);
        reg_acc(1'b0, 8'h08, 8'h00);
        check("osr reset", reg_rdata, oaf_pkg::OSR_REG_RESET);
        for (int c = 0; c < 7; c++) begin
            ratio_select_pins = 3'(c);
            pins_next = 3'(c);
            do_reset(1'b1);
            check("hw mode", sw_mode, 0);
            run(c, 1'b0);
        end
        // pins moved mid-run must only take effect after busy falls
        ratio_select_pins = 3'h1;
        pins_next = 3'h3;
        do_reset(1'b1);
        run(1, 1'b0);
        // no busy fall since, so this level must not be taken
        ratio_select_pins = 3'h5;
        run(3, 1'b1);
        convert_start = 1'b1;
        tick(1);
        convert_start = 1'b0;
        tick(40);
        do_reset(1'b0);
        check("cleared", rd_data, 0);
        run(3, 1'b0);
        ratio_select_pins = 3'h7;
        pins_next = 3'h7;
        do_reset(1'b1);
        check("sw mode", sw_mode, 1);
        reg_acc(1'b1, 8'h09, 8'h05);
        check("unmapped", reg_rdata, 0);
        reg_acc(1'b0, 8'h08, 8'h00);
        check("osr kept", reg_rdata, 0);
        for (int s = 8; s >= 0; s--) begin
            reg_acc(1'b1, 8'h08, 8'(s));
            check("osr", reg_rdata, 8'(s));
            run(s, 1'b0);
        end
        // codes 0x09 to 0x0F fall back to 256
        osr_val = 8'h09 + 8'($urandom % 7);
        reg_acc(1'b1, 8'h08, osr_val);
        check("osr wide", reg_rdata, osr_val);
        run(int'(oaf_pkg::SHIFT_MAX), 1'b0);
        conclude();
    end
    // longest legal run is far below this span
    initial begin
        #3_000_000;
        error_cnt++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        conclude();
    end
endmodule : tb
